// ---- inc/sms_pkg.sv ----
`default_nettype none

package sms_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] CTRL_IDX    = 8'h9d;
  localparam logic [7:0] STAT_IDX    = 8'h9e;
  localparam logic [7:0] DATA_IDX    = 8'h9f;

  // Control register fields.
  localparam int         CTRL_EN_B   = 7;
  localparam int         CTRL_MASTER_SELECT_B = 5;
  localparam int         CTRL_CLOCK_IDLE_LEVEL_B = 4;
  localparam int         CTRL_CLOCK_SAMPLE_EDGE_B = 3;
  localparam logic [7:0] CTRL_MASK   = 8'hbf;
  localparam logic [7:0] CTRL_RESET  = 8'h00;

  // Status register fields.
  localparam int         STAT_DONE_B = 7;
  localparam int         STAT_WRITE_COLLISION_FLAG_B = 6;
  localparam int         STAT_TXE_B  = 3;
  localparam int         STAT_BIT_ORDER_SELECT_B = 2;
  localparam int         STAT_IRQE_B = 0;

  // Transfer geometry.
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [4:0] LAST_EDGE   = 5'h0f;
  localparam logic [7:0] IDLE_BYTE   = 8'h00;

  // Half SCK period for divider code 0, in system clocks.
  localparam logic [8:0] HALF_BASE   = 9'h002;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    ST_IDLE  = 1'b0,
    ST_SHIFT = 1'b1
  } sms_state_t;

endpackage

`default_nettype wire

// ---- rtl/sms_clkdiv.sv ----
`default_nettype none

module sms_clkdiv
  import sms_pkg::*;
(
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       resetn,
  // Control.
  input  wire logic       run,
  input  wire logic [2:0] sel,
  // Half-period strobe.
  output logic            tick
);

  logic [8:0] cnt_q;
  logic [8:0] term;

  // Code n gives half period 2<<n, so SCK is the system clock over 4<<n.
  assign term = 9'((HALF_BASE << sel) - 9'h001);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 9'h000;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= 9'h000;
      tick  <= 1'b0;
    end else if (cnt_q == term) begin
      cnt_q <= 9'h000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= 9'(cnt_q + 9'h001);
      tick  <= 1'b0;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_tick_spacing: assert property (tick |=> !tick)
    else $error("divider strobe closer than two cycles");

endmodule

`default_nettype wire

// ---- rtl/sms_port.sv ----
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none

module sms_port
  import sms_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              resetn,
  // AXI4-Lite write channels.
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Serial pins, output enables active low.
  input  wire logic              sck_i,
  output logic                   sck_o,
  output logic                   sck_oe_n,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe_n,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe_n,
  input  wire logic              sel_n_i,
  // Transfer-done interrupt request.
  output logic                   irq
);

  if (ADDR_W < 10 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must be 10 to 32");
  end

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        idx);
    addr_hit = ((a >> 2) == ADDR_W'(idx)) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic tx_bit(input logic [7:0] d,
                                  input logic [3:0] i,
                                  input logic       lsb_first);
    if (i >= BYTE_BITS) begin
      tx_bit = 1'b0;
    end else if (lsb_first) begin
      tx_bit = d[i[2:0]];
    end else begin
      tx_bit = d[3'(3'd7 - i[2:0])];
    end
  endfunction

  logic [ADDR_W-1:0] aw_addr_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [7:0]        w_data_q;
  logic              w_lane_q;
  logic [7:0]        ctrl_q;
  logic              done_q;
  logic              write_collision_flag_q;
  logic              bit_order_select_q;
  logic              irqe_q;
  logic [7:0]        tx_q;
  logic              tx_full_q;
  logic [7:0]        rx_q;
  logic [4:0]        ecnt_q;
  logic              sck_prev_q;
  sms_state_t        st_q;

  logic wr_go, wr_ctrl, wr_stat, wr_data, wr_bad;
  logic en, master_select, clock_idle_level, clock_sample_edge, slave_sel, tick;
  logic m_edge, s_edge, edge_ev, samp, drive, last;
  logic active, start_m, coll, load, in_bit, out_d;
  logic [3:0] nxt_idx;
  logic [7:0] rd_d;
  logic       rd_err;

  // Write decode.
  assign wr_go   = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign wr_ctrl = wr_go & w_lane_q & addr_hit(aw_addr_q, CTRL_IDX);
  assign wr_stat = wr_go & w_lane_q & addr_hit(aw_addr_q, STAT_IDX);
  assign wr_data = wr_go & w_lane_q & addr_hit(aw_addr_q, DATA_IDX);
  assign wr_bad  = !(addr_hit(aw_addr_q, CTRL_IDX)
                   | addr_hit(aw_addr_q, STAT_IDX)
                   | addr_hit(aw_addr_q, DATA_IDX));

  assign en        = ctrl_q[CTRL_EN_B];
  assign master_select      = ctrl_q[CTRL_MASTER_SELECT_B];
  assign clock_idle_level      = ctrl_q[CTRL_CLOCK_IDLE_LEVEL_B];
  assign clock_sample_edge      = ctrl_q[CTRL_CLOCK_SAMPLE_EDGE_B];
  assign slave_sel = en & ~master_select & ~sel_n_i;

  // Edges: master from the divider, slave from the pin, gated by select
  // and by a pending done flag so a finished byte is not overrun.
  assign m_edge  = tick & (st_q == ST_SHIFT) & en & master_select;
  assign s_edge  = slave_sel & ~done_q & (sck_i != sck_prev_q);
  assign edge_ev = master_select ? m_edge : s_edge;
  assign samp    = edge_ev & (ecnt_q[0] == clock_sample_edge);
  assign drive   = edge_ev & ~samp;
  assign last    = edge_ev & (ecnt_q == LAST_EDGE);
  assign nxt_idx = 4'((6'(ecnt_q) + 6'h01 + {5'h00, ~clock_sample_edge}) >> 1);
  assign in_bit  = master_select ? miso_i : mosi_i;

  assign active  = master_select ? (st_q == ST_SHIFT) : (slave_sel & (ecnt_q != 5'h00));
  assign start_m = wr_data & en & master_select & (st_q == ST_IDLE);
  assign coll    = wr_data & en & active;
  assign load    = wr_data & ~coll;

  sms_clkdiv u_div (
    .clock  (clock),
    .resetn (resetn),
    .run    (st_q == ST_SHIFT),
    .sel    (ctrl_q[2:0]),
    .tick   (tick)
  );

  // AXI write address and data, taken in either order.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_have_q     <= 1'b0;
      aw_addr_q     <= '0;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_q     <= 1'b1;
      aw_addr_q     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end else if (wr_go) begin
      aw_have_q     <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      w_have_q     <= 1'b0;
      w_data_q     <= 8'h00;
      w_lane_q     <= 1'b0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_q     <= 1'b1;
      w_data_q     <= s_axi_wdata[7:0];
      w_lane_q     <= s_axi_wstrb[0];
      s_axi_wready <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end else if (wr_go) begin
      w_have_q     <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_bad ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read path.
  always_comb begin
    rd_d   = 8'h00;
    rd_err = 1'b0;
    if (addr_hit(s_axi_araddr, CTRL_IDX)) begin
      rd_d = ctrl_q;
    end else if (addr_hit(s_axi_araddr, STAT_IDX)) begin
      rd_d[STAT_DONE_B] = done_q;
      rd_d[STAT_WRITE_COLLISION_FLAG_B] = write_collision_flag_q;
      rd_d[STAT_TXE_B]  = ~tx_full_q;
      rd_d[STAT_BIT_ORDER_SELECT_B] = bit_order_select_q;
      rd_d[STAT_IRQE_B] = irqe_q;
    end else if (addr_hit(s_axi_araddr, DATA_IDX)) begin
      rd_d = rx_q;
    end else begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_d};
      s_axi_rresp   <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Configuration.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RESET;
      bit_order_select_q <= 1'b0;
      irqe_q <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= w_data_q & CTRL_MASK;
      end
      if (wr_stat) begin
        bit_order_select_q <= w_data_q[STAT_BIT_ORDER_SELECT_B];
        irqe_q <= w_data_q[STAT_IRQE_B];
      end
    end
  end

  // Sticky flags: software clears by writing zero, a new event wins.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      write_collision_flag_q <= 1'b0;
    end else begin
      done_q <= last
        | (done_q & ~(wr_stat & ~w_data_q[STAT_DONE_B]));
      write_collision_flag_q <= coll
        | (write_collision_flag_q & ~(wr_stat & ~w_data_q[STAT_WRITE_COLLISION_FLAG_B]));
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= done_q & irqe_q;
    end
  end

  // Master sequencing.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start_m) begin
            st_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!en || !master_select || last) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Edge counter; a high select in slave mode or a disabled port restarts the byte.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ecnt_q <= 5'h00;
    end else if (!en || (!master_select && sel_n_i) || start_m || last) begin
      ecnt_q <= 5'h00;
    end else if (edge_ev) begin
      ecnt_q <= 5'(ecnt_q + 5'h01);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_i;
    end
  end

  // Transmit register. A slave that finished a byte reverts to zeros so
  // an unwritten next byte goes out as the idle pattern.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_q      <= IDLE_BYTE;
      tx_full_q <= 1'b0;
    end else if (load) begin
      tx_q      <= w_data_q;
      tx_full_q <= 1'b1;
    end else if (last) begin
      tx_full_q <= 1'b0;
      if (!master_select) begin
        tx_q <= IDLE_BYTE;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_q <= 8'h00;
    end else if (samp) begin
      rx_q <= bit_order_select_q ? {in_bit, rx_q[7:1]}
                     : {rx_q[6:0], in_bit};
    end
  end

  // Data out: the first bit stands before any edge, later bits change
  // only on drive edges so the far side always samples stable data.
  always_comb begin
    out_d = mosi_o;
    if (ecnt_q == 5'h00 && !edge_ev) begin
      out_d = tx_bit(tx_q, 4'h0, bit_order_select_q);
    end else if (drive) begin
      out_d = tx_bit(tx_q, nxt_idx, bit_order_select_q);
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mosi_o <= 1'b0;
      miso_o <= 1'b0;
    end else begin
      mosi_o <= out_d;
      miso_o <= out_d;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_o <= 1'b0;
    end else if (st_q == ST_IDLE || !en || !master_select) begin
      sck_o <= clock_idle_level;
    end else if (m_edge) begin
      sck_o <= ~sck_o;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sck_oe_n  <= 1'b1;
      mosi_oe_n <= 1'b1;
      miso_oe_n <= 1'b1;
    end else begin
      sck_oe_n  <= ~(en & master_select);
      mosi_oe_n <= ~(en & master_select);
      miso_oe_n <= ~slave_sel;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_sck_idle_level: assert property (
    $past(st_q == ST_IDLE) && $stable(ctrl_q) |-> sck_o == clock_idle_level)
    else $error("SCK not at idle level");
  a_done_on_last: assert property (last |=> done_q)
    else $error("done flag missed end of byte");
  a_write_collision_flag_keeps_tx: assert property (
    coll && master_select |=> write_collision_flag_q && $stable(tx_q))
    else $error("collision changed transmit data");
  a_write_collision_flag_no_abort: assert property (
    coll && st_q == ST_SHIFT && !last && en && master_select
    |=> st_q == ST_SHIFT && irq == $past(done_q && irqe_q))
    else $error("collision aborted transfer");
  a_irq_follows_done: assert property (
    done_q && irqe_q |=> irq)
    else $error("interrupt not raised");
  a_slave_hold_rx: assert property (
    done_q && !master_select |=> $stable(rx_q))
    else $error("slave took data while done pending");
  a_unsel_no_count: assert property (
    en && !master_select && sel_n_i |=> ecnt_q == 5'h00)
    else $error("unselected slave counted edges");
  a_miso_float: assert property (!slave_sel |=> miso_oe_n)
    else $error("MISO driven while unselected");
  a_start_master: assert property (
    st_q == ST_IDLE ##1 st_q == ST_SHIFT |-> $past(en && master_select))
    else $error("transfer started outside master mode");

  c_master_byte: cover property (last && master_select);
  c_slave_byte:  cover property (last && !master_select);
  c_collision:   cover property (coll);

endmodule

`default_nettype wire

// ---- tb/sms_far_model.sv ----
`default_nettype none

module sms_far_model (
  // Clock.
  input  wire logic       clock,
  // Resolved bus wires.
  input  wire logic       sck_w,
  input  wire logic       mosi_w,
  input  wire logic       miso_w,
  // Settings shared with the port.
  input  wire logic       role,
  input  wire logic       clock_idle_level,
  input  wire logic       clock_sample_edge,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  // Drives toward the port.
  output logic            far_sck,
  output logic            far_mosi,
  output logic            far_miso,
  output logic            sel_n,
  output logic [7:0]      rx
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       prev;
  logic [4:0] cnt;
  logic [4:0] pos;
  logic [7:0] sr;

  initial begin
    far_sck = 1'b0;
    far_mosi = 1'b0;
    sel_n = 1'b1;
    rx = 8'h00;
    sr = 8'h00;
    cnt = 5'h00;
    prev = 1'b0;
  end

  // Slave role: each bit stands for two edges, so its index is half the count.
  assign pos = cnt - {4'h0, clock_sample_edge};
  assign far_miso = tx[lsb ? pos[3:1] : 3'h7 - pos[3:1]];

  always @(posedge clock) begin
    prev <= sck_w;
    if (!role) begin
      cnt <= 5'h00;
    end else if (sck_w !== prev) begin
      cnt <= (cnt == 5'h0f) ? 5'h00 : cnt + 5'h01;
      if (cnt[0] == clock_sample_edge) begin
        sr = lsb ? {mosi_w, sr[7:1]} : {sr[6:0], mosi_w};
        rx <= sr;
      end
    end
  end

  // Master role: every SCK level lasts four system clocks.
  task automatic xfer(input logic [7:0] t, input logic s,
                      output logic [7:0] r);
    int e;
    r = 8'h00;
    @(posedge clock);
    far_sck <= clock_idle_level;
    @(posedge clock);
    sel_n <= !s;
    far_mosi <= t[lsb ? 0 : 7] ^ clock_sample_edge;
    for (e = 1; e <= 16; e++) begin
      repeat (4) @(posedge clock);
      far_sck <= ~far_sck;
      if ((e % 2) != clock_sample_edge) begin
        r = lsb ? {miso_w, r[7:1]} : {r[6:0], miso_w};
      end else if (e < 16) begin
        far_mosi <= t[lsb ? e / 2 : 7 - e / 2];
      end
    end
    repeat (4) @(posedge clock);
    sel_n <= 1'b1;
    far_mosi <= ~far_mosi;
  endtask
endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
`default_nettype none

module testbench
  import sms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] A_CTRL = {2'b00, CTRL_IDX, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, STAT_IDX, 2'b00};
  localparam logic [11:0] A_DATA = {2'b00, DATA_IDX, 2'b00};

  logic clock, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic sck_o, sck_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n;
  logic sck_w, mosi_w, miso_w, far_sck, far_mosi, far_miso, sel_n;
  logic role, clock_idle_level, clock_sample_edge, lsb, gap_on, sck_q;
  logic [7:0] b, t, v, r, ftx, frx;
  logic [2:0] code;
  int gap, tog, i, j, miscompares, n_checks;
  integer seed;

  assign sck_w = sck_oe_n ? far_sck : sck_o;
  assign mosi_w = mosi_oe_n ? far_mosi : mosi_o;
  // A released MISO shows the inverse of the last driven bit, so a slave
  // that drives too late is caught by the far master.
  assign miso_w = miso_oe_n ? (role ? far_miso : ~miso_o) : miso_o;

  sms_port dut_u (.clock(clock), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck_i(sck_w),
    .sck_o(sck_o), .sck_oe_n(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_n(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n), .sel_n_i(sel_n), .irq(irq));

  sms_far_model far_u (.clock(clock), .sck_w(sck_w), .mosi_w(mosi_w),
    .miso_w(miso_w), .role(role), .clock_idle_level(clock_idle_level), .clock_sample_edge(clock_sample_edge), .lsb(lsb),
    .tx(ftx), .far_sck(far_sck), .far_mosi(far_mosi),
    .far_miso(far_miso), .sel_n(sel_n), .rx(frx));

  function automatic logic [7:0] stat_v(input logic d, w, e, l);
    return {d, w, 2'b00, e, l, 1'b0, 1'b1};
  endfunction

  function automatic int half_of(input logic [2:0] c);
    return 2 << c;
  endfunction

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d,
                    input logic [1:0] er);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata[7:0];
    chk("rresp", er, rresp);
    chk("rdata_hi", 32'h0, {8'h00, rdata[31:8]});
  endtask

  task automatic rc(input string n, input logic [11:0] a,
                    input logic [7:0] m, input logic [7:0] e);
    logic [7:0] x;
    rd(a, x, RESP_OKAY);
    chk(n, e, x & m);
  endtask

  task automatic wait_done;
    logic [7:0] x;
    for (int k = 0; k < 3000; k++) begin
      rd(A_STAT, x, RESP_OKAY);
      if (x[7] === 1'b1) break;
    end
    chk("done_wait", 1'b1, x[7]);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // The half period is measured from the second toggle on, inside frames.
  always @(posedge clock) begin
    sck_q <= sck_o;
    gap <= gap + 1;
    if (!gap_on) begin
      tog <= 0;
    end else if (sck_o !== sck_q) begin
      gap <= 1;
      tog <= tog + 1;
      if (tog >= 1 && tog < 16) chk("sck_half", half_of(code), gap);
    end
  end

  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    wrap_up();
  end

  initial begin
    seed = 32'h756a;
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hf};
    {role, clock_idle_level, clock_sample_edge, lsb, gap_on, code, ftx} = 16'h0;
    {gap, tog, miscompares, n_checks} = '0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rc("ctrl_rst", A_CTRL, 8'hff, CTRL_RESET);
    rc("stat_rst", A_STAT, 8'hfe, 8'h08);
    wr(A_CTRL, 8'hff, RESP_OKAY);
    rc("ctrl_rw", A_CTRL, 8'hff, CTRL_MASK);
    wstrb <= 4'h0;
    wr(A_CTRL, 8'h00, RESP_OKAY);
    wstrb <= 4'hf;
    rc("ctrl_strb", A_CTRL, 8'hff, CTRL_MASK);
    wr(12'h000, 8'h55, RESP_SLVERR);
    rd(12'h000, v, RESP_SLVERR);
    chk("unmapped", 8'h00, v);
    $display("test registers done");
    for (i = 0; i < 8; i++) begin
      {code, clock_idle_level, clock_sample_edge, lsb} = {i[2:0], i[0], i[1], i[2]};
      rnd = $random(seed);
      {ftx, b} = rnd[15:0];
      gap_on <= 1'b0;
      role <= 1'b0;
      wr(A_CTRL, {3'b101, clock_idle_level, clock_sample_edge, code}, RESP_OKAY);
      wr(A_STAT, stat_v(0, 0, 0, lsb), RESP_OKAY);
      gap_on <= 1'b1;
      role <= 1'b1;
      wr(A_DATA, b, RESP_OKAY);
      wr(A_DATA, ~b, RESP_OKAY);
      wait_done();
      rc("m_stat", A_STAT, 8'hff, stat_v(1, 1, 1, lsb));
      chk("m_irq", 1'b1, irq);
      chk("m_idle", clock_idle_level, sck_o);
      rc("m_rx", A_DATA, 8'hff, ftx);
      chk("far_rx", b, frx);
      wr(A_STAT, stat_v(0, 0, 0, lsb), RESP_OKAY);
      @(posedge clock);
      chk("irq_clr", 1'b0, irq);
      $display("test master %0d done", i);
    end
    gap_on <= 1'b0;
    role <= 1'b0;
    for (j = 0; j < 4; j++) begin
      rnd = $random(seed);
      {lsb, t, b} = rnd[16:0];
      {clock_idle_level, clock_sample_edge} = {j[0], j[1]};
      wr(A_CTRL, {3'b100, clock_idle_level, clock_sample_edge, 3'h0}, RESP_OKAY);
      wr(A_STAT, stat_v(0, 0, 0, lsb), RESP_OKAY);
      wr(A_DATA, b, RESP_OKAY);
      far_u.xfer(t, 1'b0, r);
      chk("s_float", 1'b1, miso_oe_n);
      rc("s_unsel", A_STAT, 8'hc0, 8'h00);
      far_u.xfer(t, 1'b1, r);
      chk("s_tx", b, r);
      wait_done();
      chk("s_irq", 1'b1, irq);
      far_u.xfer(~t, 1'b1, r);
      rc("s_hold", A_DATA, 8'hff, t);
      wr(A_STAT, stat_v(0, 0, 0, lsb), RESP_OKAY);
      fork
        far_u.xfer(~t, 1'b1, r);
        begin
          repeat (20) @(posedge clock);
          wr(A_DATA, 8'h5a, RESP_OKAY);
        end
      join
      chk("s_zero", 8'h00, r);
      rc("s_coll", A_STAT, 8'hc0, 8'hc0);
      rc("s_rx2", A_DATA, 8'hff, ~t);
      wr(A_STAT, stat_v(0, 0, 0, lsb), RESP_OKAY);
      $display("test slave %0d done", j);
    end
    wr(A_CTRL, 8'ha7, RESP_OKAY);
    wr(A_STAT, 8'h00, RESP_OKAY);
    wr(A_DATA, 8'h3c, RESP_OKAY);
    // Abort after one SCK toggle, while SCK stands away from its idle level.
    repeat (300) @(posedge clock);
    wr(A_CTRL, 8'h27, RESP_OKAY);
    @(posedge clock);
    chk("ab_sck", 1'b0, sck_o);
    chk("ab_oe", 1'b1, sck_oe_n);
    rc("ab_done", A_STAT, 8'h80, 8'h00);
    $display("test abort done");
    wrap_up();
  end
endmodule

`default_nettype wire
